// ---- design/slc_link_ctrl.v ----
`timescale 1ns/100ps
`include "slc_regs.vh"
// Operation
// - decode strap into 12-bit low freq, 12-bit high freq or 10-bit mode
// - pixel clock divided by 1, 1.5 or 2 per mode; receiver multiplies back
// - after decoding, send selected mode to remote serializer over back channel
// - forward frame is 28 bits; its layout depends on the mode
// - forward payload is scrambled and dc balanced; receiver undoes both
// - line rate is 28 times divided pixel clock, at most 1.4 Gbps
// - never enable both camera inputs at once
// - active input chosen by select pin or control register bit
// - back-channel driver follows the active input
// - one parity bit per forward frame, four crc bits on back channel
// - link errors counted in 8-bit registers
// - forward parity counters clear on loss of lock
// - pass output goes low on forward parity error
// - back-channel crc error counts readable at SLC_REG_BC_CRC_A and SLC_REG_BC_CRC_B
// - scl and sda driven open drain: pull low or release
// - i2c slave works up to 400 kbps fast mode
// - stretch scl at ninth clock until remote answers; never drive clock otherwise
// - forward remote transactions only while pass-through is enabled
module slc_link_ctrl (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        pdb,
   input  wire [1:0]  mode_strap_resistor,
   input  wire        lock,
   input  wire        cam_sel_pin,
   input  wire        frame_valid,
   input  wire [27:0] frame_data,
   input  wire        bc_crc_err,
   input  wire        bc_mode_ready,
   input  wire        scl_in,
   input  wire        sda_in,
   input  wire        fwd_rsp_valid,
   input  wire        fwd_rsp_ack,
   input  wire [7:0]  fwd_rsp_data,
   output reg  [1:0]  op_mode,
   output reg  [1:0]  div_num,
   output reg  [1:0]  div_den,
   output reg         bc_mode_valid,
   output reg  [1:0]  bc_mode_word,
   output reg         in_en_a,
   output reg         in_en_b,
   output reg         bc_drv_a,
   output reg         bc_drv_b,
   output reg         pix_valid,
   output reg  [11:0] pix_data,
   output reg         line_sync,
   output reg         frame_sync,
   output reg         pass,
   output reg         scl_out,
   output reg         scl_oe,
   output reg         sda_out,
   output reg         sda_oe,
   output reg         fwd_req_valid,
   output reg  [1:0]  fwd_req_kind,
   output reg  [7:0]  fwd_req_data,
   output reg         fwd_stop
);
   localparam S_IDLE = 6'b000001;
   localparam S_RECV = 6'b000010;
   localparam S_ACK  = 6'b000100;
   localparam S_WAIT = 6'b001000;
   localparam S_SEND = 6'b010000;
   localparam S_MACK = 6'b100000;
   localparam integer TSU_INT = `SLC_TSU_DAT_CYC;
   localparam [3:0]   TSU_CYC = TSU_INT[3:0];

   wire [6:0] sync_q;
   wire       scl_s  = sync_q[0];
   wire       sda_s  = sync_q[1];
   wire       sel_s  = sync_q[2];
   wire       lock_s = sync_q[3];
   wire       pdb_s  = sync_q[4];
   wire [1:0] strap_s = sync_q[6:5];

   reg        scl_q;
   reg        sda_q;
   reg        lock_q;
   reg        pdb_q;
   reg [7:0]  ctrl;
   reg [15:0] lfsr;
   reg        act_b;
   reg [5:0]  state;
   reg [7:0]  shreg;
   reg [3:0]  bcnt;
   reg        addr_phase;
   reg        is_read;
   reg        is_local;
   reg        ptr_set;
   reg [7:0]  ptr;
   reg [7:0]  rdbyte;
   reg        rsp_seen;
   reg [3:0]  tsu_cnt;
   reg [1:0]  next_mode;
   reg [7:0]  rd_mux;

   wire [7:0] crc_a;
   wire [7:0] crc_b;
   wire [7:0] par_a;
   wire [7:0] par_b;

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire i2c_start = scl_s & scl_q & sda_q & ~sda_s;
   wire i2c_stop  = scl_s & scl_q & ~sda_q & sda_s;
   wire lock_lost = lock_q & ~lock_s;
   wire pd_exit   = pdb_s & ~pdb_q;
   wire next_act_b = ctrl[`SLC_CTRL_SEL_SRC] ? ctrl[`SLC_CTRL_SEL_B] : sel_s;

   // forward frame checking: parity over the frame as sent, then undo balance and scrambling
   wire        par_err = frame_valid & (^frame_data);
   wire [25:0] unbal = frame_data[`SLC_FRAME_DC_INV] ? ~frame_data[25:0] : frame_data[25:0];
   wire [25:0] plain = unbal ^ {lfsr[9:0], lfsr};
   wire [15:0] next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};

   slc_sync #(.W(7)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({mode_strap_resistor, pdb, lock, cam_sel_pin, sda_in, scl_in}),
      .q     (sync_q)
   );

   // back-channel crc errors, counted against the active input
   slc_err_cnt u_crc_a (
      .mclk  (mclk),
      .rst_b (rst_b),
      .inc   (bc_crc_err & ~act_b),
      .clr   (1'b0),
      .count (crc_a)
   );

   slc_err_cnt u_crc_b (
      .mclk  (mclk),
      .rst_b (rst_b),
      .inc   (bc_crc_err & act_b),
      .clr   (1'b0),
      .count (crc_b)
   );

   // forward parity errors, cleared when lock drops
   slc_err_cnt u_par_a (
      .mclk  (mclk),
      .rst_b (rst_b),
      .inc   (par_err & lock_s & ~act_b),
      .clr   (lock_lost),
      .count (par_a)
   );

   slc_err_cnt u_par_b (
      .mclk  (mclk),
      .rst_b (rst_b),
      .inc   (par_err & lock_s & act_b),
      .clr   (lock_lost),
      .count (par_b)
   );

   always @* begin
      case (strap_s)
         `SLC_STRAP_0K:  next_mode = `SLC_MODE_12B_LF;
         `SLC_STRAP_3K:  next_mode = `SLC_MODE_12B_HF;
         `SLC_STRAP_11K: next_mode = `SLC_MODE_10B;
         default:        next_mode = `SLC_MODE_12B_LF; // open strap falls back to slowest
      endcase
   end

   always @* begin
      case (ptr)
         `SLC_REG_BC_CRC_A:  rd_mux = crc_a;
         `SLC_REG_BC_CRC_B:  rd_mux = crc_b;
         `SLC_REG_FWD_PAR_A: rd_mux = par_a;
         `SLC_REG_FWD_PAR_B: rd_mux = par_b;
         `SLC_REG_CTRL:      rd_mux = ctrl;
         `SLC_REG_STATUS:    rd_mux = {3'b000, pass, act_b, lock_s, op_mode};
         default:            rd_mux = 8'h00;
      endcase
   end

   // mode capture and back-channel mode message
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pdb_q         <= 1'b0;
         op_mode       <= `SLC_MODE_12B_LF;
         div_num       <= 2'd1;
         div_den       <= 2'd1;
         bc_mode_valid <= 1'b0;
         bc_mode_word  <= `SLC_MODE_12B_LF;
      end else begin
         pdb_q <= pdb_s;
         if (pd_exit) begin
            op_mode       <= next_mode;
            bc_mode_word  <= next_mode;
            bc_mode_valid <= 1'b1;
            case (next_mode)
               `SLC_MODE_12B_HF: begin
                  div_num <= 2'd3;
                  div_den <= 2'd2;
               end
               `SLC_MODE_10B: begin
                  div_num <= 2'd2;
                  div_den <= 2'd1;
               end
               default: begin
                  div_num <= 2'd1;
                  div_den <= 2'd1;
               end
            endcase
         end else if (bc_mode_ready) begin
            bc_mode_valid <= 1'b0;
         end
      end
   end

   // input multiplexer and back-channel drivers
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         act_b    <= 1'b0;
         in_en_a  <= 1'b0;
         in_en_b  <= 1'b0;
         bc_drv_a <= 1'b0;
         bc_drv_b <= 1'b0;
      end else begin
         act_b    <= next_act_b;
         in_en_a  <= ~next_act_b;
         in_en_b  <= next_act_b;
         // driver B only turns on once B is selected and its enable is set
         bc_drv_a <= ~next_act_b & ctrl[`SLC_CTRL_BC_EN_A];
         bc_drv_b <= next_act_b & ctrl[`SLC_CTRL_BC_EN_B];
      end
   end

   // forward frame unpacking
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lock_q     <= 1'b0;
         lfsr       <= `SLC_SCR_SEED;
         pix_valid  <= 1'b0;
         pix_data   <= 12'h000;
         line_sync  <= 1'b0;
         frame_sync <= 1'b0;
         pass       <= 1'b0;
      end else begin
         lock_q    <= lock_s;
         pix_valid <= frame_valid & lock_s;
         if (!lock_s) begin
            lfsr <= `SLC_SCR_SEED; // scrambler restarts with the next lock
            pass <= 1'b0;
         end else if (frame_valid) begin
            lfsr <= next_lfsr;
            pass <= ~par_err;
            if (op_mode == `SLC_MODE_10B) begin
               pix_data   <= {2'b00, plain[9:0]};
               line_sync  <= plain[`SLC_LS_10B];
               frame_sync <= plain[`SLC_FS_10B];
            end else begin
               pix_data   <= plain[11:0];
               line_sync  <= plain[`SLC_LS_12B];
               frame_sync <= plain[`SLC_FS_12B];
            end
         end
      end
   end

   // i2c slave with pass-through
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q         <= 1'b1;
         sda_q         <= 1'b1;
         state         <= S_IDLE;
         ctrl          <= `SLC_CTRL_RESET;
         shreg         <= 8'h00;
         bcnt          <= 4'h0;
         addr_phase    <= 1'b0;
         is_read       <= 1'b0;
         is_local      <= 1'b0;
         ptr_set       <= 1'b0;
         ptr           <= 8'h00;
         rdbyte        <= 8'h00;
         rsp_seen      <= 1'b0;
         tsu_cnt       <= 4'h0;
         scl_out       <= 1'b0;
         scl_oe        <= 1'b0;
         sda_out       <= 1'b0;
         sda_oe        <= 1'b0;
         fwd_req_valid <= 1'b0;
         fwd_req_kind  <= `SLC_FWD_ADDR;
         fwd_req_data  <= 8'h00;
         fwd_stop      <= 1'b0;
      end else begin
         scl_q         <= scl_s;
         sda_q         <= sda_s;
         scl_out       <= 1'b0;
         sda_out       <= 1'b0;
         fwd_req_valid <= 1'b0;
         fwd_stop      <= 1'b0;
         if (i2c_stop) begin
            fwd_stop <= ~state[0] & ~is_local & ~addr_phase;
            state    <= S_IDLE;
            scl_oe   <= 1'b0;
            sda_oe   <= 1'b0;
         end else if (i2c_start) begin
            state      <= S_RECV;
            bcnt       <= 4'h0;
            addr_phase <= 1'b1;
            ptr_set    <= 1'b0;
            scl_oe     <= 1'b0;
            sda_oe     <= 1'b0;
         end else begin
            case (state)
               S_RECV: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bcnt  <= bcnt + 4'h1;
                  end else if (scl_fall && bcnt == 4'h8) begin
                     bcnt <= 4'h0;
                     if (addr_phase) begin
                        is_read  <= shreg[0];
                        is_local <= (shreg[7:1] == `SLC_SLAVE_ADDR);
                     end
                     if (addr_phase ? (shreg[7:1] == `SLC_SLAVE_ADDR) : is_local) begin
                        sda_oe <= 1'b1;
                        state  <= S_ACK;
                        if (!addr_phase && !ptr_set) begin
                           ptr     <= shreg;
                           ptr_set <= 1'b1;
                        end else if (!addr_phase) begin
                           if (ptr == `SLC_REG_CTRL) begin
                              ctrl <= {3'b000, shreg[4:0]};
                           end
                           ptr <= ptr + 8'h01;
                        end
                     end else if (ctrl[`SLC_CTRL_PASSTHRU]) begin
                        scl_oe        <= 1'b1;
                        fwd_req_valid <= 1'b1;
                        fwd_req_kind  <= addr_phase ? `SLC_FWD_ADDR : `SLC_FWD_WRITE;
                        fwd_req_data  <= shreg;
                        rsp_seen      <= 1'b0;
                        state         <= S_WAIT;
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_WAIT: begin
                  // hold the clock low until the far side answers, then let data settle
                  if (!rsp_seen && fwd_rsp_valid) begin
                     rsp_seen <= 1'b1;
                     rdbyte   <= fwd_rsp_data;
                     tsu_cnt  <= 4'h0;
                     if (fwd_req_kind != `SLC_FWD_RDNEXT) begin
                        sda_oe <= fwd_rsp_ack;
                     end
                  end else if (rsp_seen) begin
                     tsu_cnt <= tsu_cnt + 4'h1;
                     if (tsu_cnt == TSU_CYC - 4'h1) begin
                        scl_oe <= 1'b0;
                        if (fwd_req_kind == `SLC_FWD_RDNEXT) begin
                           state <= S_MACK;
                        end else if (sda_oe) begin
                           state <= S_ACK;
                        end else begin
                           state <= S_IDLE;
                        end
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     addr_phase <= 1'b0;
                     if (addr_phase && is_read) begin
                        shreg  <= is_local ? rd_mux : rdbyte;
                        sda_oe <= is_local ? ~rd_mux[7] : ~rdbyte[7];
                        bcnt   <= 4'h0;
                        if (is_local) begin
                           ptr <= ptr + 8'h01;
                        end
                        state <= S_SEND;
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= S_RECV;
                     end
                  end
               end
               S_SEND: begin
                  if (scl_fall) begin
                     bcnt <= bcnt + 4'h1;
                     if (bcnt == 4'h7) begin
                        sda_oe <= 1'b0;
                        if (is_local) begin
                           state <= S_MACK;
                        end else begin
                           scl_oe        <= 1'b1;
                           fwd_req_valid <= 1'b1;
                           fwd_req_kind  <= `SLC_FWD_RDNEXT;
                           fwd_req_data  <= 8'h00;
                           rsp_seen      <= 1'b0;
                           state         <= S_WAIT;
                        end
                     end else begin
                        shreg  <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise && sda_s) begin
                     state <= S_IDLE; // master ends the read
                  end else if (scl_fall) begin
                     shreg  <= is_local ? rd_mux : rdbyte;
                     sda_oe <= is_local ? ~rd_mux[7] : ~rdbyte[7];
                     bcnt   <= 4'h0;
                     if (is_local) begin
                        ptr <= ptr + 8'h01;
                     end
                     state <= S_SEND;
                  end
               end
               S_IDLE: begin
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
               end
               default: begin
                  state  <= S_IDLE;
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // slc_link_ctrl

// ---- shared/slc_regs.vh ----
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

// register offsets (i2c pointer values)
`define SLC_REG_BC_CRC_A      8'h0a
`define SLC_REG_BC_CRC_B      8'h0b
`define SLC_REG_FWD_PAR_A     8'h1a
`define SLC_REG_FWD_PAR_B     8'h1b
`define SLC_REG_CTRL          8'h20
`define SLC_REG_STATUS        8'h21

// control register fields
`define SLC_CTRL_SEL_SRC      0
`define SLC_CTRL_SEL_B        1
`define SLC_CTRL_PASSTHRU     2
`define SLC_CTRL_BC_EN_A      3
`define SLC_CTRL_BC_EN_B      4
`define SLC_CTRL_RESET        8'h18

// status register fields
`define SLC_STAT_MODE_LO      0
`define SLC_STAT_LOCK         2
`define SLC_STAT_ACT_B        3
`define SLC_STAT_PASS         4

// own i2c slave address
`define SLC_SLAVE_ADDR        7'h30

// strap codes from the mode resistor comparator
`define SLC_STRAP_0K          2'b00
`define SLC_STRAP_3K          2'b01
`define SLC_STRAP_11K         2'b10

// operating modes
`define SLC_MODE_12B_LF       2'b00
`define SLC_MODE_12B_HF       2'b01
`define SLC_MODE_10B          2'b10

// forward frame layout
`define SLC_FRAME_BITS        28
`define SLC_FRAME_PARITY      27
`define SLC_FRAME_DC_INV      26
`define SLC_LS_12B            12
`define SLC_FS_12B            13
`define SLC_LS_10B            10
`define SLC_FS_10B            11
`define SLC_SCR_SEED          16'hace1
`define SLC_BC_CRC_BITS       4
`define SLC_MAX_LINE_MBPS     1400

// forwarded request kinds
`define SLC_FWD_ADDR          2'b00
`define SLC_FWD_WRITE         2'b01
`define SLC_FWD_RDNEXT        2'b10

// timing
`define SLC_MCLK_MHZ          50
`define SLC_I2C_MAX_KBPS      400
`define SLC_TSU_DAT_NS        100
`define SLC_TSU_DAT_CYC       ((`SLC_TSU_DAT_NS * `SLC_MCLK_MHZ + 999) / 1000)

`endif

// ---- design/slc_sync.v ----
`timescale 1ns/100ps
module slc_sync #(
   parameter W = 1
) (
   input  wire         mclk,
   input  wire         rst_b,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // slc_sync

// ---- design/slc_err_cnt.v ----
`timescale 1ns/100ps
module slc_err_cnt (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire       inc,
   input  wire       clr,
   output reg  [7:0] count
);
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 8'h00;
      end else if (clr) begin
         // an error in the clearing cycle is still counted
         count <= inc ? 8'h01 : 8'h00;
      end else if (inc && count != 8'hff) begin
         count <= count + 8'h01; // saturates so software never sees a wrap
      end
   end
endmodule // slc_err_cnt

// ---- test/slc_link_ctrl_props.sv ----
`timescale 1ns/100ps
module slc_chk (
   input wire        mclk,
   input wire        rst_b,
   input wire        frame_valid,
   input wire [27:0] frame_data,
   input wire        fwd_rsp_valid,
   input wire        bc_mode_ready,
   input wire [1:0]  op_mode,
   input wire [1:0]  div_num,
   input wire [1:0]  div_den,
   input wire        bc_mode_valid,
   input wire [1:0]  bc_mode_word,
   input wire        in_en_a,
   input wire        in_en_b,
   input wire        bc_drv_a,
   input wire        bc_drv_b,
   input wire        pix_valid,
   input wire        pass,
   input wire        scl_oe,
   input wire        fwd_req_valid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // data gets 5 cycles of setup before scl is let go
   sequence stretch_tail;
      scl_oe [*5] ##[1:3] !scl_oe;
   endsequence
   sequence bad_frame;
      frame_valid && ^frame_data;
   endsequence
   one_input_a: assert property (!(in_en_a && in_en_b))
      else $error("both inputs enabled");
   drv_follow_a: assert property ((bc_drv_a |-> in_en_a) and (bc_drv_b |-> in_en_b))
      else $error("driver on for idle input");
   mode_ratio_a: assert property ({div_num, div_den} ==
      (op_mode == 2'h1 ? 4'he : op_mode == 2'h2 ? 4'h9 : 4'h5))
      else $error("divide ratio wrong");
   mode_hold_a: assert property (bc_mode_valid && !bc_mode_ready |=>
      bc_mode_valid && $stable(bc_mode_word)) else $error("mode word dropped");
   mode_word_a: assert property (bc_mode_valid |-> bc_mode_word == op_mode)
      else $error("mode word differs");
   pix_timing_a: assert property (pix_valid |-> $past(frame_valid))
      else $error("pixel without frame");
   pass_low_a: assert property (bad_frame |=> !pass)
      else $error("pass high after parity error");
   stretch_end_a: assert property (fwd_rsp_valid && scl_oe |=> stretch_tail)
      else $error("stretch release wrong");
   stretch_cause_a: assert property ($rose(scl_oe) |-> fwd_req_valid)
      else $error("clock held without forwarding");
endmodule // slc_chk
bind slc_link_ctrl slc_chk slc_chk_i (.*);

// ---- test/slc_far.sv ----
`timescale 1ns/100ps
module slc_far (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire       scl,
   input  wire       sda,
   input  wire       fwd_req_valid,
   input  wire       bc_mode_valid,
   input  wire [9:0] rsp_wait,
   output reg        m_scl_low = 1'b0,
   output reg        m_sda_low = 1'b0,
   output reg        fwd_rsp_valid,
   output reg        fwd_rsp_ack,
   output reg  [7:0] fwd_rsp_data,
   output reg        bc_mode_ready,
   output int        req_count
);
   localparam int Q = 32;
   reg [9:0] cnt;
   reg       mode_seen;
   // remote side: answers each forwarded byte after rsp_wait cycles
   always @(negedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 10'h0;
         fwd_rsp_valid <= 1'b0;
         fwd_rsp_ack <= 1'b0;
         fwd_rsp_data <= 8'h0;
         bc_mode_ready <= 1'b0;
         mode_seen <= 1'b0;
         req_count <= 0;
      end else begin
         fwd_rsp_valid <= (cnt == 10'h1);
         fwd_rsp_ack <= 1'b1;
         // no stale byte outside a response
         fwd_rsp_data <= (cnt == 10'h1) ? 8'h5a : 8'ha5;
         // accept the mode word a cycle late so the hold rule is exercised
         mode_seen <= bc_mode_valid;
         bc_mode_ready <= bc_mode_valid & mode_seen;
         if (fwd_req_valid) begin
            cnt <= rsp_wait;
            req_count <= req_count + 1;
         end else if (cnt != 10'h0)
            cnt <= cnt - 10'h1;
      end
   end
   task automatic qw;
      repeat (Q) @(negedge mclk);
   endtask
   task automatic clk_hi;
      int n;
      m_scl_low = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      m_sda_low = !b;
      qw;
      clk_hi;
      qw;
      r = sda;
      qw;
      m_scl_low = 1'b1;
      qw;
   endtask
   task automatic start;
      m_sda_low = 1'b0;
      qw;
      clk_hi;
      qw;
      m_sda_low = 1'b1;
      qw;
      m_scl_low = 1'b1;
      qw;
   endtask
   task automatic stop;
      m_sda_low = 1'b1;
      qw;
      clk_hi;
      qw;
      m_sda_low = 1'b0;
      qw;
   endtask
   task automatic wr(input logic [7:0] v, output logic ack);
      int i;
      logic r;
      for (i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd(input logic last, output logic [7:0] v);
      int i;
      logic r;
      for (i = 0; i < 8; i++) begin
         bit_io(1'b1, r);
         v = {v[6:0], r};
      end
      bit_io(last, r);
   endtask
endmodule // slc_far

// ---- test/tb_slc_link_ctrl.sv ----
`timescale 1ns/100ps
module tb_slc_link_ctrl;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        pdb = 1'b0;
   logic [1:0]  mode_strap_resistor = 2'h0;
   logic        lock = 1'b0;
   logic        cam_sel_pin = 1'b0;
   logic        frame_valid = 1'b0;
   logic [27:0] frame_data = 28'h000_0000;
   logic        bc_crc_err = 1'b0;
   logic [9:0]  rsp_wait = 10'h3;
   wire         m_scl_low, m_sda_low, fwd_rsp_valid, fwd_rsp_ack, bc_mode_ready;
   wire  [7:0]  fwd_rsp_data, fwd_req_data;
   wire  [1:0]  op_mode, div_num, div_den, bc_mode_word, fwd_req_kind;
   wire  [11:0] pix_data;
   wire         bc_mode_valid, in_en_a, in_en_b, bc_drv_a, bc_drv_b, pix_valid;
   wire         line_sync, frame_sync, pass, scl_out, scl_oe, sda_out, sda_oe;
   wire         fwd_req_valid, fwd_stop;
   int          req_count;
   int          fail_count = 0;
   int          checks_done = 0;
   logic [7:0]  rows [4] = '{8'h05, 8'h5e, 8'ha9, 8'hc5};
   logic [7:0]  v;
   logic        ack;
   // a line is low while any party pulls it, else the pull-up wins
   wire         scl_in = !(scl_oe || m_scl_low);
   wire         sda_in = !(sda_oe || m_sda_low);
   always #10 mclk = !mclk;
   slc_link_ctrl slc_link_ctrl_i (.*);
   slc_far slc_far_i (.mclk(mclk), .rst_b(rst_b), .scl(scl_in), .sda(sda_in),
      .fwd_req_valid(fwd_req_valid), .bc_mode_valid(bc_mode_valid), .rsp_wait(rsp_wait),
      .m_scl_low(m_scl_low), .m_sda_low(m_sda_low), .fwd_rsp_valid(fwd_rsp_valid),
      .fwd_rsp_ack(fwd_rsp_ack), .fwd_rsp_data(fwd_rsp_data),
      .bc_mode_ready(bc_mode_ready), .req_count(req_count));
   task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] val);
      slc_far_i.start;
      slc_far_i.wr(8'h60, ack);
      slc_far_i.wr(ptr, ack);
      slc_far_i.wr(val, ack);
      chk(ack, 1'b1);
      slc_far_i.stop;
   endtask
   task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
      slc_far_i.start;
      slc_far_i.wr(8'h60, ack);
      slc_far_i.wr(ptr, ack);
      slc_far_i.start;
      slc_far_i.wr(8'h61, ack);
      slc_far_i.rd(1'b1, v);
      slc_far_i.stop;
      chk(v, exp);
   endtask
   task automatic remote(input logic exp);
      slc_far_i.start;
      slc_far_i.wr(8'ha0, ack);
      chk(ack, exp);
      slc_far_i.stop;
   endtask
   // sync bits stay constant, so the 10-bit spacing limit holds
   task automatic frame(input logic [27:0] f);
      frame_valid = 1'b1;
      frame_data = f;
      @(negedge mclk);
      frame_valid = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      // tests need about 43k cycles; give up at 60k
      #1200000;
      fail_count++;
      print_verdict;
   end
   initial begin
      int i;
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      for (i = 0; i < 4; i++) begin
         pdb = 1'b0;
         mode_strap_resistor = rows[i][7:6];
         repeat (4) @(negedge mclk);
         pdb = 1'b1;
         repeat (8) @(negedge mclk);
         chk(op_mode, rows[i][5:4]);
         chk({div_num, div_den}, rows[i][3:0]);
         // strap moves while powered: mode must not follow
         mode_strap_resistor = ~rows[i][7:6];
         repeat (8) @(negedge mclk);
         chk(op_mode, rows[i][5:4]);
         $display("mode row %0d done", i);
      end
      rst_b = 1'b0;
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      chk({op_mode, div_num, div_den}, 6'h05);
      chk({in_en_a, in_en_b, bc_drv_a, bc_drv_b, pass, scl_oe, sda_oe}, 7'h50);
      chk({scl_out, sda_out, fwd_stop}, 3'h0);
      $display("reset test done");
      cam_sel_pin = 1'b1;
      repeat (6) @(negedge mclk);
      chk({in_en_a, in_en_b, bc_drv_a, bc_drv_b}, 4'h5);
      cam_sel_pin = 1'b0;
      reg_wr(8'h20, 8'h07);
      chk({in_en_a, in_en_b, bc_drv_a, bc_drv_b}, 4'h4);
      reg_wr(8'h20, 8'h17);
      chk({in_en_a, in_en_b, bc_drv_a, bc_drv_b}, 4'h5);
      $display("mux test done");
      lock = 1'b1;
      repeat (6) @(negedge mclk);
      frame(28'h000_0000);
      chk(pass, 1'b1);
      chk({line_sync, frame_sync, pix_data}, 14'h1ce1);
      frame(28'h000_0001);
      chk(pass, 1'b0);
      bc_crc_err = 1'b1;
      repeat (2) @(negedge mclk);
      bc_crc_err = 1'b0;
      reg_wr(8'h1b, 8'h77);
      reg_rd(8'h1b, 8'h01);
      reg_rd(8'h0b, 8'h02);
      $display("error count test done");
      remote(1'b1);
      chk({fwd_req_kind, fwd_req_data}, 10'h0a0);
      rsp_wait = 10'h190;
      remote(1'b1);
      chk(req_count, 2);
      // remote read: next byte requested while the ninth clock is held
      slc_far_i.start;
      slc_far_i.wr(8'ha1, ack);
      slc_far_i.rd(1'b1, v);
      slc_far_i.stop;
      chk(v, 8'h5a);
      chk({fwd_req_kind, fwd_req_data}, 10'h200);
      reg_wr(8'h20, 8'h13);
      remote(1'b0);
      chk(req_count, 4);
      $display("pass-through test done");
      lock = 1'b0;
      repeat (6) @(negedge mclk);
      reg_rd(8'h1b, 8'h00);
      reg_rd(8'h40, 8'h00);
      $display("lock loss test done");
      print_verdict;
   end
endmodule // tb_slc_link_ctrl
